// *** src/pob_cfg.svh ***
// Constants for the on/off, protect and fault command block
// Functional notes
// R1 - Operation bit 7 turns converter off/on
// R2 - Decode margin field: off, low, high
// R3 - Operation bits 6,1,0 have no effect
// R4 - Config bits 4,1,0 always read one
// R5 - Config bit 3 honours on/off bit
// R6 - Config bit 2 honours enable pin
// R7 - Pin only: enable pin starts switcher
// R8 - Command only: on/off bit starts switcher
// R9 - Both: bit and pin must agree
// R10 - Neither: start after address detection
// R11 - Lock levels allow listed commands only
// R12 - Zero unlocks all; others are fault data
// R13 - Clear faults clears all status flags
// R14 - Clear faults releases alert output
// R15 - Persisting fault sets flag, alert again
// R16 - Clear faults never restarts latched converter
// R17 - Off then on restarts latched converter
// R18 - Host avoids clearing with no alert
// R19 - Store copies operating values to memory; code copies only config bits 3 and 2
// R20 - Device may ignore bus during copy
// R21 - Host limits memory store cycles
// R22 - Restore reloads operating values from memory; code reloads only config bits 3 and 2
// R23 - Unsupported command: ack, ignore, flag comms
// R24 - Write: address, command, data, each acked
// R25 - Read: command, restart, one byte, nack
// R26 - Latched flags stay; raw bits follow
// R27 - Blocked write acked but discarded
// R28 - Unused bits read zero unless fixed
`ifndef POB_CFG_SVH
`define POB_CFG_SVH
`define CMD_OP      8'h01
`define CMD_CFG     8'h02
`define CMD_CLR     8'h03
`define CMD_WP      8'h10
`define CMD_STORE   8'h11
`define CMD_RESTORE 8'h12
`define CMD_STAT    8'h78
`define WP_ALL      8'h80
`define WP_OP       8'h40
`define WP_CFG      8'h20
`define WP_NONE     8'h00
`define OP_KEEP     8'hbc
`define CFG_FIXED   8'h13
`define CFG_CMD_RST 1'b0
`define CFG_PIN_RST 1'b1
`define SYNC_RST    14'h3000
`define MG_LOW_IGN  4'h5
`define MG_LOW_ACT  4'h6
`define MG_HI_IGN   4'h9
`define MG_HI_ACT   4'ha
`define CLK_NS      50
`define NVM_COPY_NS 100000
`define NVM_COPY_CYC (`NVM_COPY_NS / `CLK_NS)
`define ADDR_DET_NS 1000
`define ADDR_DET_CYC (`ADDR_DET_NS / `CLK_NS)
`endif

// *** src/pob_pkg.sv ***
// Types for the on/off, protect and fault command block
package pob_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RX    = 5'h02,
    ST_ACK   = 5'h04,
    ST_TX    = 5'h08,
    ST_TXACK = 5'h10
  } pob_state_e;
  typedef struct packed {
    logic ov;
    logic oc;
    logic uv;
    logic temp;
  } pob_cond_s;
  typedef struct packed {
    logic ov;
    logic oc;
    logic uv;
    logic temp;
    logic cml;
  } pob_flags_s;
endpackage

// *** src/pob_cmd_regs.sv ***
// Command register logic behind the two-wire management bus
`timescale 1ns/100ps
`include "pob_cfg.svh"
module pob_cmd_regs (
  input  wire logic              CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic              SCL_IN,
  input  wire logic              SDA_IN,
  output logic                   SDA_OUT,
  output logic                   SDA_OE_OUT,
  output logic                   ALERT_OUT,
  output logic                   ALERT_OE_OUT,
  input  wire logic [6:0]        ADDR_IN,
  input  wire logic              EN_PIN_IN,
  input  wire pob_pkg::pob_cond_s COND_IN,
  output logic                   CONV_ON_OUT,
  output logic [1:0]             MARGIN_OUT,
  output logic                   MARGIN_ACT_OUT,
  output logic                   NVM_BUSY_OUT
);
  // Synchroniser stages for all pins
  logic [13:0]          sync1;
  logic [13:0]          sync2;
  logic                 scl;      // Synced bus clock
  logic                 sda;      // Synced bus data
  logic                 en_pin;   // Synced enable pin
  logic [6:0]           addr_pin; // Synced strap
  pob_pkg::pob_cond_s   cond;     // Synced fault conditions
  logic                 scl_d;    // Previous bus clock
  logic                 sda_d;    // Previous bus data
  logic                 rise;
  logic                 fall;
  logic                 start;
  logic                 stop;
  // Bus engine state
  pob_pkg::pob_state_e  state;
  logic [2:0]           cnt;      // Bit counter
  logic [1:0]           phase;    // 0 addr, 1 cmd, 2 data
  logic                 rw;       // Read transfer
  logic                 got;      // Eight bits received
  logic [7:0]           shreg;    // Receive shifter
  logic [7:0]           txsh;     // Transmit shifter
  logic [7:0]           cmd;      // Command pointer
  logic                 cmd_evt;  // Command byte taken
  logic                 wr_evt;   // Data byte taken
  logic [7:0]           rdata;    // Read mux
  logic                 ack_now;
  // Strap detection
  logic [6:0]           det_cnt;
  logic                 addr_done;
  logic [6:0]           dev_addr;
  // Operating registers
  logic [7:0]           op_reg;
  logic                 cfg_cmd;
  logic                 cfg_pin;
  logic [7:0]           wlock;
  logic                 nvm_cmd;  // Stored config bit 3
  logic                 nvm_pin;  // Stored config bit 2
  logic [11:0]          busy_cnt;
  logic                 nvm_busy;
  pob_pkg::pob_flags_s  flags;
  logic                 clr;
  logic                 ok_now;
  logic                 known;
  // Converter control
  logic                 src_on;
  logic                 fault_now;
  logic                 latch_off;

  // Lock level check per command
  function automatic logic wr_ok(input logic [7:0] c, input logic [7:0] wp);
    case (wp)
      `WP_NONE: wr_ok = 1'b1; // R12
      `WP_CFG:  wr_ok = (c == `CMD_WP) || (c == `CMD_OP) || (c == `CMD_CFG); // R11
      `WP_OP:   wr_ok = (c == `CMD_WP) || (c == `CMD_OP); // R11
      default:  wr_ok = (c == `CMD_WP); // R11
    endcase
  endfunction

  // Two flip-flops on every pin
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sync1 <= `SYNC_RST; // Bus lines idle high, no false edge
      sync2 <= `SYNC_RST;
    end else begin
      sync1 <= {SCL_IN, SDA_IN, EN_PIN_IN, ADDR_IN, COND_IN};
      sync2 <= sync1;
    end
  end
  assign {scl, sda, en_pin, addr_pin, cond} = sync2;

  // Edge history of bus lines
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end
  assign rise  = scl & ~scl_d;
  assign fall  = ~scl & scl_d;
  assign start = scl & scl_d & sda_d & ~sda;
  assign stop  = scl & scl_d & ~sda_d & sda;

  // Strap capture after release
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      det_cnt   <= 7'h00;
      addr_done <= 1'b0;
      dev_addr  <= 7'h00;
    end else if (!addr_done) begin
      det_cnt <= det_cnt + 7'h01;
      if (det_cnt == 7'(`ADDR_DET_CYC)) begin
        addr_done <= 1'b1;
        dev_addr  <= addr_pin;
      end
    end
  end

  // Acknowledge decision; address byte refused while copying
  assign ack_now = (phase != 2'h0) || (addr_done && !nvm_busy && shreg[7:1] == dev_addr); // R20 R24

  // Bus engine
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state      <= pob_pkg::ST_IDLE;
      cnt        <= 3'h0;
      phase      <= 2'h0;
      rw         <= 1'b0;
      got        <= 1'b0;
      shreg      <= 8'h00;
      txsh       <= 8'h00;
      cmd        <= 8'h00;
      cmd_evt    <= 1'b0;
      wr_evt     <= 1'b0;
      SDA_OE_OUT <= 1'b0;
      SDA_OUT    <= 1'b0;
    end else begin
      cmd_evt <= 1'b0;
      wr_evt  <= 1'b0;
      if (start) begin
        // Start or repeated start
        state      <= pob_pkg::ST_RX;
        cnt        <= 3'h0;
        phase      <= 2'h0;
        got        <= 1'b0;
        SDA_OE_OUT <= 1'b0;
      end else if (stop) begin
        state      <= pob_pkg::ST_IDLE;
        SDA_OE_OUT <= 1'b0;
      end else begin
        case (state)
          pob_pkg::ST_RX: begin
            if (rise) begin
              shreg <= {shreg[6:0], sda};
              cnt   <= cnt + 3'h1;
              got   <= (cnt == 3'h7);
            end else if (fall && got) begin
              // Byte done; ack and act
              got        <= 1'b0;
              state      <= pob_pkg::ST_ACK;
              SDA_OE_OUT <= ack_now; // R23 R24
              if (phase == 2'h0) begin
                rw <= shreg[0];
              end else if (phase == 2'h1) begin
                cmd     <= shreg;
                cmd_evt <= 1'b1;
              end else begin
                wr_evt <= 1'b1;
              end
            end
          end
          pob_pkg::ST_ACK: begin
            if (fall) begin
              cnt <= 3'h0;
              if (!SDA_OE_OUT) begin
                state <= pob_pkg::ST_IDLE;
              end else if (phase == 2'h0 && rw) begin
                // Return one byte
                state      <= pob_pkg::ST_TX;
                txsh       <= rdata; // R25
                SDA_OE_OUT <= ~rdata[7];
              end else begin
                state      <= pob_pkg::ST_RX;
                SDA_OE_OUT <= 1'b0;
                if (phase != 2'h2) begin
                  phase <= phase + 2'h1;
                end
              end
            end
          end
          pob_pkg::ST_TX: begin
            if (fall) begin
              cnt <= cnt + 3'h1;
              if (cnt == 3'h7) begin
                state      <= pob_pkg::ST_TXACK;
                SDA_OE_OUT <= 1'b0;
              end else begin
                txsh       <= {txsh[6:0], 1'b0};
                SDA_OE_OUT <= ~txsh[6];
              end
            end
          end
          pob_pkg::ST_TXACK: begin
            if (rise && sda) begin
              state <= pob_pkg::ST_IDLE; // R25
            end else if (fall) begin
              state      <= pob_pkg::ST_TX;
              cnt        <= 3'h0;
              txsh       <= rdata;
              SDA_OE_OUT <= ~rdata[7];
            end
          end
          default: begin
            state <= pob_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Read mux; unused bits zero
  always_comb begin
    case (cmd)
      `CMD_OP:   rdata = op_reg; // R28
      `CMD_CFG:  rdata = `CFG_FIXED | {4'h0, cfg_cmd, cfg_pin, 2'h0}; // R4 R28
      `CMD_WP:   rdata = wlock;
      `CMD_STAT: rdata = {1'b0, ~CONV_ON_OUT, flags.ov, flags.oc, flags.uv, flags.temp, flags.cml, 1'b0}; // R26
      default:   rdata = 8'h00;
    endcase
  end

  // Command qualification
  assign ok_now = wr_ok(cmd, wlock); // R11
  assign known  = (cmd == `CMD_OP) || (cmd == `CMD_CFG) || (cmd == `CMD_WP) || (cmd == `CMD_CLR) ||
                  (cmd == `CMD_STORE) || (cmd == `CMD_RESTORE) || (cmd == `CMD_STAT);
  assign clr    = cmd_evt && cmd == `CMD_CLR && ok_now; // R13

  // Operating registers
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      op_reg  <= 8'h00;
      cfg_cmd <= `CFG_CMD_RST;
      cfg_pin <= `CFG_PIN_RST;
      wlock   <= `WP_NONE;
    end else if (wr_evt && ok_now) begin // R27
      case (cmd)
        `CMD_OP:  op_reg <= shreg & `OP_KEEP; // R3
        `CMD_CFG: begin
          cfg_cmd <= shreg[3]; // R5
          cfg_pin <= shreg[2]; // R6
        end
        `CMD_WP: begin
          if (shreg == `WP_NONE || shreg == `WP_ALL || shreg == `WP_OP || shreg == `WP_CFG) begin
            wlock <= shreg; // R12
          end
        end
        default: begin
        end
      endcase
    end else if (cmd_evt && cmd == `CMD_RESTORE && ok_now) begin
      cfg_cmd <= nvm_cmd; // R22
      cfg_pin <= nvm_pin; // R22
    end
  end

  // Non-volatile copy and busy window
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      nvm_cmd  <= `CFG_CMD_RST;
      nvm_pin  <= `CFG_PIN_RST;
      busy_cnt <= 12'h000;
    end else if (cmd_evt && ok_now && (cmd == `CMD_STORE || cmd == `CMD_RESTORE)) begin
      busy_cnt <= 12'(`NVM_COPY_CYC); // R20
      if (cmd == `CMD_STORE) begin
        nvm_cmd <= cfg_cmd; // R19
        nvm_pin <= cfg_pin; // R19
      end
    end else if (busy_cnt != 12'h000) begin
      busy_cnt <= busy_cnt - 12'h001;
    end
  end
  assign nvm_busy = (busy_cnt != 12'h000);

  // Latched flags; set wins over clear
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      flags <= '0;
    end else begin
      flags.ov   <= (flags.ov & ~clr) | cond.ov; // R13 R15 R26
      flags.oc   <= (flags.oc & ~clr) | cond.oc; // R15 R26
      flags.uv   <= (flags.uv & ~clr) | cond.uv; // R15 R26
      flags.temp <= (flags.temp & ~clr) | cond.temp; // R15 R26
      flags.cml  <= (flags.cml & ~clr) | (cmd_evt && !known) |
                    (wr_evt && cmd != `CMD_OP && cmd != `CMD_CFG && cmd != `CMD_WP) |
                    (wr_evt && ok_now && cmd == `CMD_WP && shreg != `WP_NONE && shreg != `WP_ALL &&
                     shreg != `WP_OP && shreg != `WP_CFG); // R23 R12
    end
  end

  // Alert pulled low while any flag set
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ALERT_OE_OUT <= 1'b0;
      ALERT_OUT    <= 1'b0;
    end else begin
      ALERT_OE_OUT <= |flags; // R14 R15
      ALERT_OUT    <= 1'b0;
    end
  end

  // Enable source selection
  always_comb begin
    case ({cfg_cmd, cfg_pin})
      2'h1:    src_on = en_pin; // R7
      2'h2:    src_on = op_reg[7]; // R1 R8
      2'h3:    src_on = op_reg[7] && en_pin; // R9
      default: src_on = addr_done; // R10
    endcase
  end
  assign fault_now = cond.ov | cond.oc;

  // Fault latch-off, released by source off
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      latch_off   <= 1'b0;
      CONV_ON_OUT <= 1'b0;
    end else begin
      if (!src_on) begin
        latch_off <= 1'b0; // R17
      end else if (fault_now) begin
        latch_off <= 1'b1; // R16
      end
      CONV_ON_OUT <= src_on && !latch_off && !fault_now; // R1 R16
    end
  end

  // Margin decode and busy output
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      MARGIN_OUT     <= 2'h0;
      MARGIN_ACT_OUT <= 1'b0;
      NVM_BUSY_OUT   <= 1'b0;
    end else begin
      NVM_BUSY_OUT <= nvm_busy;
      case (op_reg[5:2])
        `MG_LOW_IGN: {MARGIN_OUT, MARGIN_ACT_OUT} <= 3'h2; // R2
        `MG_LOW_ACT: {MARGIN_OUT, MARGIN_ACT_OUT} <= 3'h3; // R2
        `MG_HI_IGN:  {MARGIN_OUT, MARGIN_ACT_OUT} <= 3'h4; // R2
        `MG_HI_ACT:  {MARGIN_OUT, MARGIN_ACT_OUT} <= 3'h5; // R2
        default:     {MARGIN_OUT, MARGIN_ACT_OUT} <= 3'h0; // R2
      endcase
    end
  end

  // Checks
  a_pin_only: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R7
    (!cfg_cmd && cfg_pin) |=> CONV_ON_OUT == ($past(en_pin) && !$past(latch_off) && !$past(fault_now)))
    else $error("pin-only enable wrong");
  a_both_need: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R9
    (cfg_cmd && cfg_pin && !(en_pin && op_reg[7])) |=> !CONV_ON_OUT)
    else $error("both-source enable wrong");
  a_auto_start: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R10
    (!cfg_cmd && !cfg_pin && addr_done && !latch_off && !fault_now) |=> CONV_ON_OUT)
    else $error("auto start missing");
  a_latch_hold: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R16
    (latch_off && src_on) |=> !CONV_ON_OUT)
    else $error("latched converter restarted");
  a_clear_alert: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R14
    (clr && cond == '0 && !wr_evt) |=> (flags == '0) ##1 !ALERT_OE_OUT)
    else $error("alert not released");
  a_refault: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R15
    (clr && cond != '0) |=> ((flags[4:1] & $past(cond)) == $past(cond)) ##1 ALERT_OE_OUT)
    else $error("fault not set again");
  a_wp_block: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R27
    (wr_evt && !ok_now) |=> $stable(op_reg) && $stable(wlock))
    else $error("blocked write changed register");
  a_op_unused: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R3
    (op_reg[6] == 1'b0) && (op_reg[1:0] == 2'h0))
    else $error("unused operation bits set");
  a_busy_nack: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R20
    (state == pob_pkg::ST_ACK && phase == 2'h0 && nvm_busy) |-> !SDA_OE_OUT)
    else $error("acked while copying");
endmodule

// *** test/pob_host_model.sv ***
// Bus host model driving the two-wire management bus
`timescale 1ns/100ps
module pob_host_model (
  input  wire logic       clk_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            sda_low_out,
  output logic            rd_valid_out,
  output logic [7:0]      rd_data_out
);
  // Idle bus: clock stands high, data released to pull-up
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    rd_valid_out = 1'b0;
    rd_data_out = 8'h00;
  end
  // Half of a 400 ns bus clock period
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask
  // Start or repeated start, data falls while clock high
  task automatic start();
    sda_low_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_low_out = 1'b1;
    half();
    scl_out = 1'b0;
  endtask
  // Stop, data rises while clock high
  task automatic stop();
    sda_low_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_low_out = 1'b0;
    half();
  endtask
  // One bit; data moves a cycle after clock falls, sampled at end of high
  task automatic bit_io(input logic b, output logic s);
    @(negedge clk_in);
    sda_low_out = !b;
    repeat (3) @(negedge clk_in);
    scl_out = 1'b1;
    half();
    s = sda_in;
    scl_out = 1'b0;
  endtask
  // Byte out, most significant bit first, then ack slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // Write or send byte; a refused address ends the frame at once
  task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input logic has_d,
                      output logic ack);
    logic k;
    start();
    wbyte({a, 1'b0}, ack);
    if (ack) begin
      wbyte(c, k);
      ack = ack & k;
      if (has_d) begin
        wbyte(d, k);
        ack = ack & k;
      end
    end
    stop();
  endtask
  // Combined read, single byte closed by a nack
  task automatic rdx(input logic [6:0] a, input logic [7:0] c, output logic ack);
    logic k;
    logic [7:0] d;
    start();
    wbyte({a, 1'b0}, ack);
    wbyte(c, k);
    ack = ack & k;
    start();
    wbyte({a, 1'b1}, k);
    ack = ack & k;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, k);
    stop();
    rd_data_out = d;
    rd_valid_out = 1'b1;
    @(negedge clk_in);
    rd_valid_out = 1'b0;
  endtask
endmodule

// *** test/pmbus_onoff_protect_cmds_test.sv ***
// Self-checking bench for the command register block
`timescale 1ns/100ps
`include "pob_cfg.svh"
module pmbus_onoff_protect_cmds_test;
  logic              clk;          // 20 MHz clock
  logic              rst;          // Active-high reset
  logic              en;           // Enable pin
  pob_pkg::pob_cond_s cond;        // Raw fault conditions
  logic [6:0]        addr;         // Strapped address
  logic [31:0]       rnd;          // Random state
  logic              scl, host_low, sda_oe, sda, ack, rd_v, conv, busy, alert, sda_dout, alert_dout;
  logic [1:0]        marg;
  logic              mact;
  logic [7:0]        rd_d;
  logic [7:0]        exp_q[$];     // Expected read bytes
  logic [3:0]        mcode[6] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h9, 4'ha};
  logic [7:0]        mexp[6] = '{8'h00, 8'h00, 8'h02, 8'h03, 8'h04, 8'h05};
  int                n_fail, total_checks, cyc;
  // Open-drain data line with pull-up
  assign sda = !(host_low | sda_oe);
  pob_cmd_regs dut (.CLK_IN(clk), .RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_dout), .SDA_OE_OUT(sda_oe),
    .ALERT_OUT(alert_dout), .ALERT_OE_OUT(alert), .ADDR_IN(addr), .EN_PIN_IN(en), .COND_IN(cond),
    .CONV_ON_OUT(conv), .MARGIN_OUT(marg), .MARGIN_ACT_OUT(mact), .NVM_BUSY_OUT(busy));
  pob_host_model host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low),
    .rd_valid_out(rd_v), .rd_data_out(rd_d));
  // Clock generator
  initial clk = 1'b0;
  always #25 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cw(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    host.xfer(addr, c, d, 1'b1, ack);
    chk({7'h0, ack}, 8'h01);
  endtask
  task automatic sb(input logic [7:0] c);
    host.xfer(addr, c, 8'h00, 1'b0, ack);
    chk({7'h0, ack}, 8'h01);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    exp_q.push_back(e);
    host.rdx(addr, c, ack);
    chk({7'h0, ack}, 8'h01);
  endtask
  // Converter enable after settling
  task automatic cv(input logic e);
    cw(10);
    chk({7'h0, conv}, {7'h0, e});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy; i++) cw(1);
  endtask
  // Read results are compared against the oldest note
  always @(posedge clk) begin
    if (rd_v) begin
      if (exp_q.size() == 0) chk({7'h0, rd_v}, 8'h00);
      else chk(rd_d, exp_q.pop_front());
    end
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    rnd = 32'hf68945aa;
    rst = 1'b1;
    en = 1'b0;
    cond = '0;
    addr = rnd[6:0];
    cw(2);
    rst = 1'b0;
    cw(30);
    rd(`CMD_CFG, 8'h17);
    rd(`CMD_WP, 8'h00);
    // Pin only
    wr(`CMD_OP, 8'h80);
    cv(1'b0);
    en = 1'b1;
    cv(1'b1);
    // Command only; unused bits dropped
    wr(`CMD_CFG, 8'he8);
    rd(`CMD_CFG, 8'h1b);
    en = 1'b0;
    cv(1'b1);
    rnd = lfsr(rnd);
    wr(`CMD_OP, {1'b0, rnd[6], 4'h0, rnd[1:0]});
    cv(1'b0);
    rd(`CMD_OP, 8'h00);
    rnd = lfsr(rnd);
    wr(`CMD_OP, {1'b1, rnd[6], 4'h0, rnd[1:0]});
    cv(1'b1);
    rd(`CMD_OP, 8'h80);
    // Margin codes
    for (int i = 0; i < 6; i++) begin
      wr(`CMD_OP, {2'b10, mcode[i], 2'b00});
      cw(6);
      chk({5'h0, marg, mact}, mexp[i]);
    end
    // Both sources
    wr(`CMD_CFG, 8'h0c);
    wr(`CMD_OP, 8'h80);
    cv(1'b0);
    en = 1'b1;
    cv(1'b1);
    wr(`CMD_OP, 8'h00);
    cv(1'b0);
    // Neither source
    en = 1'b0;
    wr(`CMD_CFG, 8'h00);
    cv(1'b1);
    // Write protect levels
    wr(`CMD_CFG, 8'h08);
    wr(`CMD_OP, 8'h80);
    wr(`CMD_WP, `WP_ALL);
    wr(`CMD_OP, 8'h00);
    cv(1'b1);
    rd(`CMD_OP, 8'h80);
    wr(`CMD_WP, `WP_OP);
    wr(`CMD_OP, 8'h00);
    cv(1'b0);
    wr(`CMD_CFG, 8'h0c);
    rd(`CMD_CFG, 8'h1b);
    wr(`CMD_WP, `WP_CFG);
    wr(`CMD_CFG, 8'h04);
    rd(`CMD_CFG, 8'h17);
    wr(`CMD_WP, `WP_NONE);
    wr(`CMD_WP, 8'h55);
    rd(`CMD_WP, 8'h00);
    rd(`CMD_STAT, 8'h42);
    chk({7'h0, alert}, 8'h01);
    // Clearing faults
    sb(`CMD_CLR);
    rd(`CMD_STAT, 8'h40);
    chk({7'h0, alert}, 8'h00);
    wr(8'hd5, 8'h5a);
    rd(`CMD_STAT, 8'h42);
    chk({7'h0, alert}, 8'h01);
    sb(`CMD_CLR);
    cond.temp = 1'b1;
    cw(10);
    sb(`CMD_CLR);
    rd(`CMD_STAT, 8'h44);
    chk({7'h0, alert}, 8'h01);
    cond.temp = 1'b0;
    rd(`CMD_STAT, 8'h44);
    sb(`CMD_CLR);
    rd(`CMD_STAT, 8'h40);
    chk({7'h0, alert}, 8'h00);
    // Latch-off and recovery
    wr(`CMD_CFG, 8'h08);
    wr(`CMD_OP, 8'h80);
    cv(1'b1);
    cond.ov = 1'b1;
    cw(10);
    cond.ov = 1'b0;
    cv(1'b0);
    sb(`CMD_CLR);
    cv(1'b0);
    rd(`CMD_STAT, 8'h40);
    wr(`CMD_OP, 8'h00);
    wr(`CMD_OP, 8'h80);
    cv(1'b1);
    // Overcurrent latch-off with undervoltage flag
    cond = 4'b0110;
    cw(10);
    cond = '0;
    cv(1'b0);
    rd(`CMD_STAT, 8'h58);
    sb(`CMD_CLR);
    wr(`CMD_OP, 8'h00);
    wr(`CMD_OP, 8'h80);
    cv(1'b1);
    // Store and restore
    wr(`CMD_CFG, 8'h0c);
    sb(`CMD_STORE);
    chk({7'h0, busy}, 8'h01);
    host.xfer(addr, `CMD_OP, 8'h00, 1'b1, ack);
    chk({7'h0, ack}, 8'h00);
    wait_idle();
    wr(`CMD_CFG, 8'h00);
    rd(`CMD_CFG, 8'h13);
    sb(`CMD_RESTORE);
    wait_idle();
    chk({7'h0, busy}, 8'h00);
    rd(`CMD_CFG, 8'h1f);
    // Foreign address is not acked
    host.xfer(addr ^ 7'h01, `CMD_OP, 8'h00, 1'b1, ack);
    chk({7'h0, ack}, 8'h00);
    cw(10);
    chk(8'(exp_q.size()), 8'h00);
    chk({6'h0, sda_dout, alert_dout}, 8'h00);
    test_done();
  end
endmodule
